// ==== verilog/sfc_serial_frame_control.sv ====
`timescale 1ns/10ps
module sfc_serial_frame_control
  import sfc_pkg::*;
#(
  parameter int unsigned BIT_CLKS = BIT_CYCLES,
  parameter int unsigned TX_DEPTH = FIFO_DEPTH
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [15:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [15:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic             TXD,
  input  wire logic        RXD,
  input  wire logic        CTS_N
);
  localparam int unsigned CW = $clog2(BIT_CLKS + 1);
  localparam logic [CW-1:0] TICK = (CW)'(BIT_CLKS - 1);
  localparam logic [CW-1:0] HALF = (CW)'(BIT_CLKS / 2 - 1);

  if (BIT_CLKS < 4 || TX_DEPTH < 2) begin : g_chk
    $error("sfc_serial_frame_control: BIT_CLKS below 4 or TX_DEPTH below 2");
  end

  logic [7:0]    cfg_ff, lin_ff;
  logic          awready_ff, wready_ff, aw_got_ff, w_got_ff, bvalid_ff;
  logic [13:0]   aw_idx_ff;
  logic [7:0]    w_data_ff;
  logic          w_lane_ff;
  logic [1:0]    bresp_ff, rresp_ff;
  logic          arready_ff, rvalid_ff;
  logic [31:0]   rdata_ff;
  logic          rxd_s, cts_n_s;
  logic          f_in_ready, f_out_valid, f_pop;
  logic [7:0]    f_out_data;
  sfc_tx_e       tx_st_ff;
  logic [CW-1:0] tx_cnt_ff;
  logic [7:0]    tx_sh_ff, tx_char_ff;
  logic [2:0]    tx_bit_ff;
  logic          tx_stop_ff, txd_ff, pin_txd_ff;
  logic [3:0]    brk_bits_ff;
  sfc_rx_e       rx_st_ff;
  logic [CW-1:0] rx_cnt_ff;
  logic [7:0]    rx_sh_ff, rx_data_ff;
  logic [2:0]    rx_bit_ff;
  logic          rx_valid_ff, rx_perr_ff, rx_ferr_ff, rx_mp_ff, rx_xbit_ff;

  // decoded controls
  logic nine, par_eff, extra, tx_run, tx_tick, rx_tick, rx_in, lin, brk_done, brk_hw_clr;
  logic wr_tx, wr_hit, do_wr, wr_stall, rd_rx_clr, rd_take, rx_done;
  logic [3:0] dur;
  logic [31:0] rd_mux;
  logic [1:0]  rd_resp;

  assign nine     = lin_ff[LIN_NINE];
  assign lin      = lin_ff[LIN_MODE];
  assign dur      = lin_ff[LIN_DUR_LSB +: LIN_DUR_W];
  assign par_eff  = cfg_ff[CFG_PAR_ON] && !nine;
  assign extra    = par_eff || nine;
  assign tx_run   = cfg_ff[CFG_TX_ON] && (!cfg_ff[CFG_GATE] || !cts_n_s);
  assign tx_tick  = (tx_cnt_ff == TICK);
  assign rx_tick  = (rx_cnt_ff == TICK);
  assign rx_in    = cfg_ff[CFG_LOOP] ? txd_ff : rxd_s;
  assign brk_done = lin && tx_tick && ({1'b0, brk_bits_ff} + 5'd1 >= {1'b0, dur});
  assign brk_hw_clr = (tx_st_ff == TX_BRK) && cfg_ff[CFG_BRK] && brk_done;
  assign f_pop    = (tx_st_ff == TX_IDLE) && !cfg_ff[CFG_BRK] && tx_run && f_out_valid;
  assign rx_done  = (rx_st_ff == RX_STOP) && rx_tick && cfg_ff[CFG_RX_ON];

  // write decode; a data write waits while the fifo is full
  assign wr_tx    = (aw_idx_ff == TXDATA_IDX);
  assign wr_hit   = wr_tx || (aw_idx_ff == CFG_IDX) || (aw_idx_ff == LINCTL_IDX) ||
                    (aw_idx_ff == RXDATA_IDX) || (aw_idx_ff == STATUS_IDX);
  assign wr_stall = wr_tx && w_lane_ff && !f_in_ready;
  assign do_wr    = aw_got_ff && w_got_ff && !bvalid_ff && !wr_stall;
  assign rd_take  = ARVALID && arready_ff;
  assign rd_rx_clr = rd_take && (ARADDR[15:2] == RXDATA_IDX);

  sfc_sync u_rxd_sync (.CLK_SYS(CLK_SYS), .RST(RST), .din(RXD), .dout(rxd_s));
  sfc_sync u_cts_sync (.CLK_SYS(CLK_SYS), .RST(RST), .din(CTS_N), .dout(cts_n_s));

  sfc_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .CLK_SYS  (CLK_SYS),
    .RST      (RST),
    .in_valid (do_wr && wr_tx && w_lane_ff),
    .in_ready (f_in_ready),
    .in_data  (w_data_ff),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data (f_out_data)
  );

  // write address and data channels, taken in either order
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_idx_ff  <= '0;
      w_data_ff  <= '0;
      w_lane_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (AWVALID && awready_ff) begin
        aw_got_ff  <= 1'b1;
        awready_ff <= 1'b0;
        aw_idx_ff  <= AWADDR[15:2];
      end
      if (WVALID && wready_ff) begin
        w_got_ff  <= 1'b1;
        wready_ff <= 1'b0;
        w_data_ff <= WDATA[7:0];
        w_lane_ff <= WSTRB[0];
      end
      if (do_wr) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_ff && BREADY) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // control registers; a software write beats the hardware break clear
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cfg_ff <= CFG_RESET;
      lin_ff <= LIN_RESET;
    end else begin
      if (do_wr && w_lane_ff && aw_idx_ff == CFG_IDX) begin
        cfg_ff <= w_data_ff;
      end else if (brk_hw_clr) begin
        cfg_ff[CFG_BRK] <= 1'b0;
      end
      if (do_wr && w_lane_ff && aw_idx_ff == LINCTL_IDX) begin
        lin_ff <= w_data_ff;
      end
    end
  end

  // read data selection
  always_comb begin
    rd_mux  = '0;
    rd_resp = RESP_OKAY;
    case (ARADDR[15:2])
      CFG_IDX:    rd_mux[7:0] = cfg_ff;
      LINCTL_IDX: rd_mux[7:0] = lin_ff;
      RXDATA_IDX: rd_mux[7:0] = rx_data_ff;
      TXDATA_IDX: rd_mux      = '0;
      STATUS_IDX: begin
        rd_mux[ST_TX_EMPTY] = !f_out_valid;
        rd_mux[ST_TX_FULL]  = !f_in_ready;
        rd_mux[ST_TX_IDLE]  = (tx_st_ff == TX_IDLE);
        rd_mux[ST_RX_VALID] = rx_valid_ff;
        rd_mux[ST_PAR_ERR]  = rx_perr_ff;
        rd_mux[ST_FRM_ERR]  = rx_ferr_ff;
        rd_mux[ST_RX_MP]    = rx_mp_ff;
      end
      default:    rd_resp = RESP_SLVERR;
    endcase
  end

  // read channel
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= RESP_OKAY;
    end else if (rd_take) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= rd_mux;
      rresp_ff   <= rd_resp;
    end else if (rvalid_ff && RREADY) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  // transmit sequencer; a break request preempts any state
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tx_st_ff    <= TX_IDLE;
      tx_cnt_ff   <= '0;
      tx_sh_ff    <= '0;
      tx_char_ff  <= '0;
      tx_bit_ff   <= '0;
      tx_stop_ff  <= 1'b0;
      brk_bits_ff <= '0;
      txd_ff      <= 1'b1;
    end else if (cfg_ff[CFG_BRK] && tx_st_ff != TX_BRK) begin
      tx_st_ff    <= TX_BRK;
      tx_cnt_ff   <= '0;
      brk_bits_ff <= '0;
      txd_ff      <= 1'b0;
    end else begin
      tx_cnt_ff <= (tx_tick || tx_st_ff == TX_IDLE) ? '0 : tx_cnt_ff + 1'b1;
      case (tx_st_ff)
        TX_IDLE: begin
          txd_ff <= 1'b1;
          if (f_pop) begin
            tx_st_ff   <= TX_START;
            tx_sh_ff   <= f_out_data;
            tx_char_ff <= f_out_data;
            txd_ff     <= 1'b0;
          end
        end
        TX_START: if (tx_tick) begin
          tx_st_ff  <= TX_DATA;
          tx_bit_ff <= '0;
          txd_ff    <= tx_sh_ff[0];
        end
        TX_DATA: if (tx_tick) begin
          if (tx_bit_ff == 3'd7) begin
            tx_st_ff   <= extra ? TX_XTRA : TX_STOP;
            tx_stop_ff <= cfg_ff[CFG_STOP2];
            txd_ff     <= nine ? lin_ff[LIN_MPBIT] :
                          (par_eff ? (^tx_char_ff ^ cfg_ff[CFG_PAR_ODD]) : 1'b1);
          end else begin
            tx_sh_ff  <= tx_sh_ff >> 1;
            tx_bit_ff <= tx_bit_ff + 1'b1;
            txd_ff    <= tx_sh_ff[1];
          end
        end
        TX_XTRA: if (tx_tick) begin
          tx_st_ff   <= TX_STOP;
          tx_stop_ff <= cfg_ff[CFG_STOP2];
          txd_ff     <= 1'b1;
        end
        TX_STOP: if (tx_tick) begin
          if (tx_stop_ff) begin
            tx_stop_ff <= 1'b0;
          end else begin
            tx_st_ff <= TX_IDLE;
          end
        end
        TX_BRK: begin
          txd_ff <= 1'b0;
          if (!cfg_ff[CFG_BRK]) begin
            tx_st_ff <= TX_IDLE; // plain mode ends when software clears
            txd_ff   <= 1'b1;
          end else if (brk_done) begin
            tx_st_ff   <= TX_STOP;
            tx_stop_ff <= cfg_ff[CFG_STOP2];
            txd_ff     <= 1'b1;
          end else if (tx_tick) begin
            brk_bits_ff <= brk_bits_ff + 1'b1;
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // pin stays idle high while looped back
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_txd_ff <= 1'b1;
    end else begin
      pin_txd_ff <= cfg_ff[CFG_LOOP] ? 1'b1 : txd_ff;
    end
  end

  // receive sequencer; held idle while the receiver is off
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rx_st_ff   <= RX_IDLE;
      rx_cnt_ff  <= '0;
      rx_sh_ff   <= '0;
      rx_bit_ff  <= '0;
      rx_xbit_ff <= 1'b0;
    end else if (!cfg_ff[CFG_RX_ON]) begin
      rx_st_ff  <= RX_IDLE;
      rx_cnt_ff <= '0;
    end else begin
      rx_cnt_ff <= (rx_tick || rx_st_ff == RX_IDLE) ? '0 : rx_cnt_ff + 1'b1;
      case (rx_st_ff)
        RX_IDLE: if (!rx_in) begin
          rx_st_ff <= RX_START;
        end
        RX_START: if (rx_cnt_ff == HALF) begin
          rx_cnt_ff <= '0;
          rx_bit_ff <= '0;
          rx_st_ff  <= rx_in ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_tick) begin
          rx_sh_ff  <= {rx_in, rx_sh_ff[7:1]};
          rx_bit_ff <= rx_bit_ff + 1'b1;
          if (rx_bit_ff == 3'd7) begin
            rx_st_ff <= extra ? RX_XTRA : RX_STOP;
          end
        end
        RX_XTRA: if (rx_tick) begin
          rx_xbit_ff <= rx_in;
          rx_st_ff   <= RX_STOP;
        end
        RX_STOP: if (rx_tick) begin
          rx_st_ff <= RX_IDLE;
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // receive flags; a new character wins over a clearing read
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rx_valid_ff <= 1'b0;
      rx_data_ff  <= '0;
      rx_perr_ff  <= 1'b0;
      rx_ferr_ff  <= 1'b0;
      rx_mp_ff    <= 1'b0;
    end else if (rx_done) begin
      rx_valid_ff <= 1'b1;
      rx_data_ff  <= rx_sh_ff;
      rx_perr_ff  <= par_eff && (rx_xbit_ff != (^rx_sh_ff ^ cfg_ff[CFG_PAR_ODD]));
      rx_ferr_ff  <= !rx_in;
      rx_mp_ff    <= nine && rx_xbit_ff;
    end else if (rd_rx_clr) begin
      rx_valid_ff <= 1'b0;
      rx_perr_ff  <= 1'b0;
      rx_ferr_ff  <= 1'b0;
    end
  end

  assign AWREADY = awready_ff;
  assign WREADY  = wready_ff;
  assign BVALID  = bvalid_ff;
  assign BRESP   = bresp_ff;
  assign ARREADY = arready_ff;
  assign RVALID  = rvalid_ff;
  assign RDATA   = rdata_ff;
  assign RRESP   = rresp_ff;
  assign TXD     = pin_txd_ff;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  tx_off_idle_a: assert property ((tx_st_ff == TX_IDLE && !cfg_ff[CFG_TX_ON]) |=>
    tx_st_ff != TX_START) else $error("transmitter started while off");
  cts_gate_a: assert property ((tx_st_ff == TX_IDLE && cfg_ff[CFG_GATE] && cts_n_s)
    |=> tx_st_ff != TX_START) else $error("started with clear-to-send high");
  rx_off_a: assert property (!cfg_ff[CFG_RX_ON] |=> !$rose(rx_valid_ff))
    else $error("character assembled while receiver off");
  parity_bit_a: assert property ((tx_st_ff == TX_XTRA && !nine) |->
    txd_ff == (^tx_char_ff ^ cfg_ff[CFG_PAR_ODD])) else $error("wrong parity bit");
  nine_bit_a: assert property ((tx_st_ff == TX_XTRA && nine) |->
    txd_ff == lin_ff[LIN_MPBIT]) else $error("parity sent in nine-bit mode");
  brk_low_a: assert property ((tx_st_ff == TX_BRK && !cfg_ff[CFG_LOOP]) ##1
    (tx_st_ff == TX_BRK) |-> TXD == 1'b0) else $error("break not driven low");
  brk_abort_a: assert property ((cfg_ff[CFG_BRK] && tx_st_ff != TX_BRK) |=>
    tx_st_ff == TX_BRK) else $error("break did not abort transmission");
  lin_len_a: assert property ((tx_st_ff == TX_BRK && cfg_ff[CFG_BRK] && lin && tx_tick &&
    brk_bits_ff + 4'd1 < dur) |=> cfg_ff[CFG_BRK] && tx_st_ff == TX_BRK)
    else $error("lin break ended early");
  lin_end_a: assert property ((brk_hw_clr && !do_wr) |=> !cfg_ff[CFG_BRK] &&
    tx_st_ff == TX_STOP && txd_ff) else $error("lin break not closed by stop");
  two_stop_a: assert property ((tx_st_ff == TX_STOP && tx_stop_ff && tx_tick) |=>
    tx_st_ff == TX_STOP && txd_ff) else $error("second stop bit missing");
  loop_pin_a: assert property (cfg_ff[CFG_LOOP] |=> TXD && rx_in == txd_ff)
    else $error("loopback not internal");

  lin_break_c: cover property (brk_hw_clr);
  rx_char_c: cover property (rx_done && !rx_perr_ff);
  fifo_full_c: cover property (wr_stall);
  two_stop_c: cover property (tx_st_ff == TX_STOP && tx_stop_ff && tx_tick);
endmodule

// ==== verilog/sfc_pkg.sv ====
package sfc_pkg;
  // register word indices; byte address is four times the index
  localparam logic [13:0] CFG_IDX     = 14'h0f42;
  localparam logic [13:0] TXDATA_IDX  = 14'h0f50;
  localparam logic [13:0] RXDATA_IDX  = 14'h0f51;
  localparam logic [13:0] STATUS_IDX  = 14'h0f52;
  localparam logic [13:0] LINCTL_IDX  = 14'h0f53;
  localparam int unsigned ADDR_W      = 16;
  // line_frame_config fields
  localparam int unsigned CFG_TX_ON   = 7;
  localparam int unsigned CFG_RX_ON   = 6;
  localparam int unsigned CFG_GATE    = 5;
  localparam int unsigned CFG_PAR_ON  = 4;
  localparam int unsigned CFG_PAR_ODD = 3;
  localparam int unsigned CFG_BRK     = 2;
  localparam int unsigned CFG_STOP2   = 1;
  localparam int unsigned CFG_LOOP    = 0;
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  // lin control fields
  localparam int unsigned LIN_MODE    = 0;
  localparam int unsigned LIN_NINE    = 1;
  localparam int unsigned LIN_MPBIT   = 2;
  localparam int unsigned LIN_DUR_LSB = 4;
  localparam int unsigned LIN_DUR_W   = 4;
  localparam logic [7:0]  LIN_RESET   = 8'h00;
  // status fields
  localparam int unsigned ST_TX_EMPTY = 0;
  localparam int unsigned ST_TX_FULL  = 1;
  localparam int unsigned ST_TX_IDLE  = 2;
  localparam int unsigned ST_RX_VALID = 3;
  localparam int unsigned ST_PAR_ERR  = 4;
  localparam int unsigned ST_FRM_ERR  = 5;
  localparam int unsigned ST_RX_MP    = 6;
  // bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned BIT_TIME_NS   = 1600;
  localparam int unsigned BIT_CYCLES    = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_DEPTH    = 8;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_XTRA  = 3'b011,
    TX_STOP  = 3'b100,
    TX_BRK   = 3'b101
  } sfc_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_XTRA  = 3'b011,
    RX_STOP  = 3'b100
  } sfc_rx_e;
endpackage

// ==== verilog/sfc_sync.sv ====
`timescale 1ns/10ps
// three-stage synchroniser; output follows once stages two and three agree
module sfc_sync (
  input  wire logic CLK_SYS,
  input  wire logic RST,
  input  wire logic din,
  output logic      dout
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // capture chain, idles high like a serial line
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // accepted level
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      dout <= 1'b1;
    end else if (s2_ff == s3_ff) begin
      dout <= s3_ff;
    end
  end
endmodule

// ==== verilog/sfc_fifo.sv ====
`timescale 1ns/10ps
// flip-flop fifo with valid/ready on both sides
module sfc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             CLK_SYS,
  input  wire logic             RST,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST = (PW)'(DEPTH - 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("sfc_fifo: DEPTH must be 2 or more and WIDTH 1 or more");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ff;
  logic [PW-1:0]    rd_ff;
  logic [PW:0]      cnt_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_ff != FULL_CNT);
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage
  always_ff @(posedge CLK_SYS) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == LAST) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == LAST) ? '0 : rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// ==== test/sfc_remote.sv ====
`timescale 1ns/10ps
// far-side serial node: captures frames off the line and sends frames on request
module sfc_remote #(
  parameter int B = 4
) (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [8:0] q[$];
  int         t[$];
  int         now;
  // free cycle count, used to time each start edge
  always @(posedge clk) begin
    now <= now + 1;
  end
  // mid-bit samples after each start edge: 8 data bits and the bit after them
  initial begin
    logic [8:0] f;
    int         st;
    rxd = 1'b1;
    now = 0;
    forever begin
      @(negedge txd);
      st = now;
      repeat (B / 2) @(posedge clk);
      for (int j = 0; j < 9; j++) begin
        repeat (B) @(posedge clk);
        f[j] = txd;
      end
      q.push_back(f);
      t.push_back(st);
      wait (txd === 1'b1);
    end
  end
  // start, data lsb first, extra bit, stop; ends on the high stop level
  task automatic send(input logic [10:0] bits);
    for (int j = 0; j < 11; j++) begin
      rxd <= bits[j];
      repeat (B) @(posedge clk);
    end
  endtask
endmodule

// ==== test/tb_serial_frame_control.sv ====
`timescale 1ns/10ps
module tb_serial_frame_control;
  import sfc_pkg::*;
  localparam int B = 4;
  logic        CLK_SYS, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, TXD, RXD, CTS_N;
  logic [15:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rv;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rr, br;
  logic [7:0]  d, dd[2];
  logic [7:0]  cf[5] = '{8'h80, 8'h82, 8'h90, 8'h9a, 8'h98};
  logic [7:0]  ln[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h06};
  int          bad_count, checks_done, seed, lorun, hirun, lastlo, lasthi, k, i;

  sfc_serial_frame_control #(.BIT_CLKS(B)) i_sfc_serial_frame_control (
    .CLK_SYS, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
    .RREADY, .TXD, .RXD, .CTS_N);
  sfc_remote #(.B(B)) i_sfc_remote (.clk(CLK_SYS), .txd(TXD), .rxd(RXD));

  // clock
  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  // lengths of the last low and high runs on the line
  always @(posedge CLK_SYS) begin
    if (TXD) begin
      hirun <= hirun + 1;
      if (lorun > 0) lastlo <= lorun;
      lorun <= 0;
    end else begin
      lorun <= lorun + 1;
      if (hirun > 0) lasthi <= hirun;
      hirun <= 0;
    end
  end

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [13:0] ix, input logic [7:0] v);
    @(posedge CLK_SYS);
    AWADDR  <= {ix, 2'b00};
    WDATA   <= {24'h0, v};
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    br = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [13:0] ix, output logic [31:0] v);
    @(posedge CLK_SYS);
    ARADDR  <= {ix, 2'b00};
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    v = RDATA;
    rr = RRESP;
    RREADY <= 1'b0;
  endtask
  // wait for n captured frames, then make sure no more follow
  task automatic waitq(input int n);
    for (int j = 0; j < 3000 && i_sfc_remote.q.size() < n; j++) @(posedge CLK_SYS);
    repeat (16 * B) @(posedge CLK_SYS);
    chk(n, i_sfc_remote.q.size());
  endtask
  // expected data bits plus the bit that follows them
  function automatic logic [8:0] efr(input logic [7:0] v, input logic [7:0] c,
                                     input logic [7:0] l);
    logic x;
    x = l[1] ? l[2] : (^v ^ c[3]);
    return {(c[4] || l[1]) ? x : 1'b1, v};
  endfunction
  task automatic final_report;
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (40000) @(posedge CLK_SYS);
    bad_count++;
    final_report;
  end
  // main sequence
  initial begin
    seed = 32'h4340;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    AWADDR = 16'h0000;
    ARADDR = 16'h0000;
    WDATA = 32'h0;
    WSTRB = 4'hf;
    CTS_N = 1'b1;
    RST = 1'b1;
    repeat (5) @(posedge CLK_SYS);
    RST <= 1'b0;
    rd(CFG_IDX, rv); chk(CFG_RESET, rv);
    // a write without byte lane 0 is answered but changes nothing
    WSTRB <= 4'he;
    wr(CFG_IDX, 8'h40); chk(RESP_OKAY, br);
    WSTRB <= 4'hf;
    rd(CFG_IDX, rv); chk(CFG_RESET, rv);
    d = 8'($random(seed)) & 8'hfb;
    wr(CFG_IDX, d); rd(CFG_IDX, rv); chk(d, rv);
    rd(14'h0100, rv); chk(RESP_SLVERR, rr);
    wr(14'h0100, 8'h00); chk(RESP_SLVERR, br);
    // frame formats, two characters back to back, clear-to-send high and ignored
    for (k = 0; k < 5; k++) begin
      wr(LINCTL_IDX, ln[k]);
      wr(CFG_IDX, cf[k]);
      i_sfc_remote.q.delete();
      i_sfc_remote.t.delete();
      dd[0] = 8'($random(seed));
      dd[1] = 8'($random(seed));
      wr(TXDATA_IDX, dd[0]);
      wr(TXDATA_IDX, dd[1]);
      waitq(2);
      chk(efr(dd[0], cf[k], ln[k]), i_sfc_remote.q[0]);
      chk(efr(dd[1], cf[k], ln[k]), i_sfc_remote.q[1]);
      i = (i_sfc_remote.t[1] - i_sfc_remote.t[0] + B / 2) / B;
      chk(10 + (cf[k][4] | ln[k][1]) + cf[k][1], i);
    end
    // transmitter off, then gated by clear-to-send
    wr(LINCTL_IDX, 8'h00);
    wr(CFG_IDX, 8'h00);
    i_sfc_remote.q.delete();
    wr(TXDATA_IDX, 8'h5a);
    waitq(0);
    // one word queued, transmitter idle: empty low, full low, idle high
    rd(STATUS_IDX, rv); chk(32'h4, rv & 32'h7);
    wr(CFG_IDX, 8'ha0);
    waitq(0);
    CTS_N <= 1'b0;
    waitq(1);
    chk(efr(8'h5a, 8'ha0, 8'h00), i_sfc_remote.q[0]);
    // receive: good parity, bad parity, receiver off
    wr(CFG_IDX, 8'h50);
    for (k = 0; k < 3; k++) begin
      if (k == 2) wr(CFG_IDX, 8'h10);
      d = 8'($random(seed));
      i_sfc_remote.send({1'b1, ^d ^ (k == 1), d, 1'b0});
      repeat (2 * B) @(posedge CLK_SYS);
      rd(STATUS_IDX, rv);
      chk((k < 2 ? 8 : 0) | (k == 1 ? 16 : 0), rv & 32'h38);
      if (k < 2) begin
        rd(RXDATA_IDX, rv); chk(d, rv);
      end
    end
    // loopback: line stays idle, receiver gets the character
    wr(CFG_IDX, 8'hc1);
    i_sfc_remote.q.delete();
    d = 8'($random(seed));
    wr(TXDATA_IDX, d);
    waitq(0);
    rd(RXDATA_IDX, rv); chk(d, rv);
    // plain break, timed by software after the transmitter went idle
    wr(CFG_IDX, 8'h84);
    repeat (20 * B) @(posedge CLK_SYS);
    chk(0, TXD);
    wr(CFG_IDX, 8'h80);
    repeat (4) @(posedge CLK_SYS);
    chk(1, TXD);
    chk(1, lastlo >= 20 * B);
    // hardware-timed break of 3 bit times, two stops, then a queued character
    wr(LINCTL_IDX, 8'h31);
    wr(CFG_IDX, 8'h86);
    wr(TXDATA_IDX, 8'hff);
    for (i = 0; i < 500 && TXD !== 1'b1; i++) @(posedge CLK_SYS);
    repeat (2) @(posedge CLK_SYS);
    chk(3 * B, lastlo);
    rd(CFG_IDX, rv); chk(8'h82, rv);
    repeat (4 * B) @(posedge CLK_SYS);
    chk(1, lasthi >= 2 * B && lasthi <= 2 * B + 2);
    // reset in mid-character: line goes idle, control word back to reset
    @(posedge CLK_SYS);
    RST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    chk(1, TXD);
    RST <= 1'b0;
    rd(CFG_IDX, rv); chk(CFG_RESET, rv);
    final_report;
  end
endmodule
